// ### rtl/ctr_fault_status.sv
// two-channel fault and caution status logic for a high-speed counter
// assumes all inputs come from logic on core_clk_i; no synchronisers needed
//
// Operation
// (R1) any channel fault lights the shared i/o error indicator
// (R2) fault sets channel fault flag and stores its decimal code
// (R3) channel clear command drops the fault flag
// (R4) channel clear command returns the fault code to zero, normal
// (R5) linear range overflow stores 3100/4100 and halts that channel's linear counting
// (R6) pulse span overflow stores 3200/4200 and halts pulse measurement
// (R7) software recovers pulse overflow by re-presenting target or restarting measurement
// (R8) software recovers linear overflow by presetting a new counter value
// (R9) a pending fault code is never overwritten by a later fault
// (R10) clear while cause persists detects and stores the fault again
// (R11) software removes the cause before issuing the clear command
// (R12) caution sets channel caution flag and stores its decimal code
// (R13) a caution never halts channel operation
// (R14) caution code always takes the latest caution
// (R15) channel clear command also drops the caution flag
// (R16) channel clear command also zeroes the caution code
// (R17) sampling overflow stores 3050/4050, saturates at the bound, keeps counting
// (R18) caution clear while cause persists detects and stores it again
// (R19) each channel keeps fully independent status
`timescale 1ns/1ps
// ------------------------------------------------------------------
// one channel
// ------------------------------------------------------------------
module ctr_fault_channel #(
   parameter logic [15:0] LIN_CODE   = 16'h0000,
   parameter logic [15:0] PULSE_CODE = 16'h0000,
   parameter logic [15:0] SAMP_CODE  = 16'h0000
) (
   // clock and reset
   input  wire logic                      core_clk_i,
   input  wire logic                      reset_n_i,
   input  wire logic                      ce_i,
   // conditions and commands
   input  wire ctr_fault_pkg::fault_cond_t cond_i,
   input  wire logic                      clear_cmd_i,
   input  wire logic                      preset_i,
   input  wire logic                      pulse_restart_i,
   input  wire logic                      samp_valid_i,
   input  wire logic [32:0]               samp_raw_i,
   // status
   output ctr_fault_pkg::ch_status_t      status_o,
   output logic                           lin_halt_o,
   output logic                           pulse_halt_o,
   output logic [31:0]                    samp_value_o
);
   ctr_fault_pkg::ch_status_t status_r;
   logic                      lin_halt_r;
   logic                      pulse_halt_r;
   logic [31:0]               samp_value_r;
   logic                      any_fault;
   logic                      samp_ovf;
   logic [15:0]               fault_new_code;
   assign any_fault      = cond_i.lin_ovf | cond_i.pulse_ovf;
   // linear overflow takes precedence when both arrive together
   assign fault_new_code = cond_i.lin_ovf ? LIN_CODE : PULSE_CODE;
   // out of signed 32-bit range when the two top bits of the wide value disagree
   assign samp_ovf       = samp_valid_i & (samp_raw_i[32] ^ samp_raw_i[31]);
   // ----------------------------------------------------------------
   // fault flag and code
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         status_r.fault_flag <= ctr_fault_pkg::FLAG_RESET;
         status_r.fault_code <= ctr_fault_pkg::CODE_NORMAL;
      end else if (ce_i) begin
         // (R2) flag and code on fault
         // (R10) set wins over clear, persistent cause re-detected
         if (any_fault && (!status_r.fault_flag || clear_cmd_i)) begin
            status_r.fault_flag <= 1'b1;
            status_r.fault_code <= fault_new_code;
         // (R3) clear drops flag
         // (R4) clear zeroes code
         end else if (clear_cmd_i) begin
            status_r.fault_flag <= 1'b0;
            status_r.fault_code <= ctr_fault_pkg::CODE_NORMAL;
         end
         // (R9) otherwise the first code stands
      end
   end
   // ----------------------------------------------------------------
   // caution flag and code
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         status_r.caution_flag <= ctr_fault_pkg::FLAG_RESET;
         status_r.caution_code <= ctr_fault_pkg::CODE_NORMAL;
      end else if (ce_i) begin
         // (R12) flag and code on caution
         // (R14) always the latest code
         // (R18) set wins over clear
         if (samp_ovf) begin
            status_r.caution_flag <= 1'b1;
            status_r.caution_code <= SAMP_CODE;
         // (R15) clear drops caution flag
         // (R16) clear zeroes caution code
         end else if (clear_cmd_i) begin
            status_r.caution_flag <= 1'b0;
            status_r.caution_code <= ctr_fault_pkg::CODE_NORMAL;
         end
      end
   end
   // ----------------------------------------------------------------
   // halts; only faults stop anything
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lin_halt_r <= 1'b0;
      end else if (ce_i) begin
         // (R5) linear overflow halts this channel's linear counting
         if (cond_i.lin_ovf) begin
            lin_halt_r <= 1'b1;
         // (R8) preset releases the halt
         end else if (preset_i) begin
            lin_halt_r <= 1'b0;
         end
      end
   end
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pulse_halt_r <= 1'b0;
      end else if (ce_i) begin
         // (R6) span overflow halts measurement
         if (cond_i.pulse_ovf) begin
            pulse_halt_r <= 1'b1;
         // (R7) restart releases the halt
         end else if (pulse_restart_i) begin
            pulse_halt_r <= 1'b0;
         end
      end
   end
   // ----------------------------------------------------------------
   // sampling value with saturation
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         samp_value_r <= ctr_fault_pkg::SAMP_RESET;
      end else if (ce_i && samp_valid_i) begin
         // (R17) saturate at the exceeded bound, no halt
         // (R13) caution leaves counting running
         if (samp_ovf) begin
            samp_value_r <= samp_raw_i[32] ? ctr_fault_pkg::SAMP_MIN : ctr_fault_pkg::SAMP_MAX;
         end else begin
            samp_value_r <= samp_raw_i[31:0];
         end
      end
   end
   assign status_o     = status_r;
   assign lin_halt_o   = lin_halt_r;
   assign pulse_halt_o = pulse_halt_r;
   assign samp_value_o = samp_value_r;
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   a_fault_lin_set: assert property (ce_i && cond_i.lin_ovf && !status_r.fault_flag // (R2)
      |=> status_r.fault_flag && status_r.fault_code == LIN_CODE)
      else $error("linear fault not recorded");
   a_fault_pulse_set: assert property (ce_i && cond_i.pulse_ovf && !cond_i.lin_ovf && !status_r.fault_flag // (R6)
      |=> status_r.fault_code == PULSE_CODE ##0 pulse_halt_r)
      else $error("pulse fault not recorded");
   a_fault_code_kept: assert property (ce_i && status_r.fault_flag && !clear_cmd_i // (R9)
      |=> $stable(status_r.fault_code) && status_r.fault_flag)
      else $error("pending fault code overwritten");
   a_fault_clear_flag: assert property (ce_i && clear_cmd_i && !any_fault |=> !status_r.fault_flag) // (R3)
      else $error("fault flag not cleared");
   a_fault_clear_code: assert property (ce_i && clear_cmd_i && !any_fault // (R4)
      |=> status_r.fault_code == ctr_fault_pkg::CODE_NORMAL)
      else $error("fault code not cleared");
   a_fault_redetect: assert property (ce_i && clear_cmd_i && cond_i.lin_ovf // (R10)
      |=> status_r.fault_flag && status_r.fault_code == LIN_CODE)
      else $error("persistent fault lost on clear");
   a_lin_halt_hold: assert property (ce_i && cond_i.lin_ovf ##1 (!ce_i || !preset_i)[*2] // (R5)
      |=> lin_halt_r)
      else $error("linear halt released without preset");
   a_caution_latest: assert property (ce_i && samp_ovf // (R14)
      |=> status_r.caution_flag && status_r.caution_code == SAMP_CODE)
      else $error("caution code not updated");
   a_caution_clear: assert property (ce_i && clear_cmd_i && !samp_ovf // (R16)
      |=> !status_r.caution_flag && status_r.caution_code == ctr_fault_pkg::CODE_NORMAL)
      else $error("caution not cleared");
   a_caution_no_halt: assert property (ce_i && samp_ovf && !any_fault && !lin_halt_r && !pulse_halt_r // (R13)
      |=> !lin_halt_r && !pulse_halt_r)
      else $error("caution halted the channel");
   a_samp_saturate: assert property (ce_i && samp_ovf && !samp_raw_i[32] |=> samp_value_r == ctr_fault_pkg::SAMP_MAX) // (R17)
      else $error("sampling value not saturated high");
   c_fault_then_clear: cover property (ce_i && cond_i.lin_ovf ##[1:20] ce_i && clear_cmd_i && !any_fault);
   c_second_fault: cover property (status_r.fault_flag && ce_i && cond_i.pulse_ovf);
   c_caution_low_sat: cover property (ce_i && samp_ovf && samp_raw_i[32]);
endmodule : ctr_fault_channel
// ------------------------------------------------------------------
// top: two channels and the shared indicator
// ------------------------------------------------------------------
module ctr_fault_status (
   // clock and reset
   input  wire logic                       core_clk_i,
   input  wire logic                       reset_n_i,
   input  wire logic                       ce_i,
   // channel 1 conditions and commands
   input  wire ctr_fault_pkg::fault_cond_t ch1_cond_i,
   input  wire logic                       ch1_fault_clear_cmd_i,
   input  wire logic                       ch1_preset_i,
   input  wire logic                       ch1_pulse_restart_i,
   input  wire logic                       ch1_samp_valid_i,
   input  wire logic [32:0]                ch1_samp_raw_i,
   // channel 2 conditions and commands
   input  wire ctr_fault_pkg::fault_cond_t ch2_cond_i,
   input  wire logic                       ch2_fault_clear_cmd_i,
   input  wire logic                       ch2_preset_i,
   input  wire logic                       ch2_pulse_restart_i,
   input  wire logic                       ch2_samp_valid_i,
   input  wire logic [32:0]                ch2_samp_raw_i,
   // channel 1 status
   output logic                            ch1_fault_flag_o,
   output logic                            ch1_caution_flag_o,
   output logic [15:0]                     ch1_fault_code_word_o,
   output logic [15:0]                     ch1_caution_code_word_o,
   output logic                            ch1_lin_halt_o,
   output logic                            ch1_pulse_halt_o,
   output logic [31:0]                     ch1_samp_value_o,
   // channel 2 status
   output logic                            ch2_fault_flag_o,
   output logic                            ch2_caution_flag_o,
   output logic [15:0]                     ch2_fault_code_word_o,
   output logic [15:0]                     ch2_caution_code_word_o,
   output logic                            ch2_lin_halt_o,
   output logic                            ch2_pulse_halt_o,
   output logic [31:0]                     ch2_samp_value_o,
   // shared indicator
   output logic                            io_err_o
);
   ctr_fault_pkg::ch_status_t st1;
   ctr_fault_pkg::ch_status_t st2;
   // (R19) separate instances, no shared state
   ctr_fault_channel #(
      .LIN_CODE   (ctr_fault_pkg::CH1_LIN_CODE),
      .PULSE_CODE (ctr_fault_pkg::CH1_PULSE_CODE),
      .SAMP_CODE  (ctr_fault_pkg::CH1_SAMP_CODE)
   ) u_ch1 (
      .core_clk_i      (core_clk_i),
      .reset_n_i       (reset_n_i),
      .ce_i            (ce_i),
      .cond_i          (ch1_cond_i),
      .clear_cmd_i     (ch1_fault_clear_cmd_i),
      .preset_i        (ch1_preset_i),
      .pulse_restart_i (ch1_pulse_restart_i),
      .samp_valid_i    (ch1_samp_valid_i),
      .samp_raw_i      (ch1_samp_raw_i),
      .status_o        (st1),
      .lin_halt_o      (ch1_lin_halt_o),
      .pulse_halt_o    (ch1_pulse_halt_o),
      .samp_value_o    (ch1_samp_value_o)
   );
   ctr_fault_channel #(
      .LIN_CODE   (ctr_fault_pkg::CH2_LIN_CODE),
      .PULSE_CODE (ctr_fault_pkg::CH2_PULSE_CODE),
      .SAMP_CODE  (ctr_fault_pkg::CH2_SAMP_CODE)
   ) u_ch2 (
      .core_clk_i      (core_clk_i),
      .reset_n_i       (reset_n_i),
      .ce_i            (ce_i),
      .cond_i          (ch2_cond_i),
      .clear_cmd_i     (ch2_fault_clear_cmd_i),
      .preset_i        (ch2_preset_i),
      .pulse_restart_i (ch2_pulse_restart_i),
      .samp_valid_i    (ch2_samp_valid_i),
      .samp_raw_i      (ch2_samp_raw_i),
      .status_o        (st2),
      .lin_halt_o      (ch2_lin_halt_o),
      .pulse_halt_o    (ch2_pulse_halt_o),
      .samp_value_o    (ch2_samp_value_o)
   );
   assign ch1_fault_flag_o        = st1.fault_flag;
   assign ch1_caution_flag_o      = st1.caution_flag;
   assign ch1_fault_code_word_o   = st1.fault_code;
   assign ch1_caution_code_word_o = st1.caution_code;
   assign ch2_fault_flag_o        = st2.fault_flag;
   assign ch2_caution_flag_o      = st2.caution_flag;
   assign ch2_fault_code_word_o   = st2.fault_code;
   assign ch2_caution_code_word_o = st2.caution_code;
   // (R1) indicator follows any pending fault; cautions do not light it
   assign io_err_o = st1.fault_flag | st2.fault_flag;
   default clocking cbt @(posedge core_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   a_io_err_lamp: assert property (ce_i && (ch1_cond_i.lin_ovf || ch2_cond_i.pulse_ovf) |=> io_err_o) // (R1)
      else $error("error indicator not lit");
   a_ch2_isolated: assert property (ce_i && ch1_cond_i.lin_ovf && !ch2_cond_i.lin_ovf && !ch2_cond_i.pulse_ovf // (R19)
      && !ch2_fault_clear_cmd_i |=> $stable(st2.fault_code))
      else $error("channel 1 fault disturbed channel 2");
   c_both_faulted: cover property (st1.fault_flag && st2.fault_flag);
endmodule : ctr_fault_status

// ### rtl/ctr_fault_pkg.sv
// constants and carrier types for the two-channel counter fault/caution status block
// assumes the counting datapaths report fault conditions as same-clock levels
package ctr_fault_pkg;

   // ----------------------------------------------------------------
   // status codes, decimal values written in hex
   // ----------------------------------------------------------------
   localparam logic [15:0] CODE_NORMAL    = 16'h0000; // 0
   localparam logic [15:0] CH1_LIN_CODE   = 16'h0c1c; // 3100
   localparam logic [15:0] CH2_LIN_CODE   = 16'h1004; // 4100
   localparam logic [15:0] CH1_PULSE_CODE = 16'h0c80; // 3200
   localparam logic [15:0] CH2_PULSE_CODE = 16'h1068; // 4200
   localparam logic [15:0] CH1_SAMP_CODE  = 16'h0bea; // 3050
   localparam logic [15:0] CH2_SAMP_CODE  = 16'h0fd2; // 4050

   // ----------------------------------------------------------------
   // sampling count bounds and reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] SAMP_MAX       = 32'h7fffffff;
   localparam logic [31:0] SAMP_MIN       = 32'h80000000;
   localparam logic [31:0] SAMP_RESET     = 32'h00000000;
   localparam logic        FLAG_RESET     = 1'b0;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic lin_ovf;    // linear current value left signed 32-bit range
      logic pulse_ovf;  // measured pulse beyond measurable span
   } fault_cond_t;

   typedef struct packed {
      logic        fault_flag;
      logic        caution_flag;
      logic [15:0] fault_code;
      logic [15:0] caution_code;
   } ch_status_t;

endpackage : ctr_fault_pkg

// ### verif/ctr_fault_status_tb.sv
// self-checking bench for the two-channel fault and caution status block
// assumes one 50 MHz clock; inputs change on the falling edge, outputs are read a cycle later
`timescale 1ns/1ps

module ctr_fault_status_tb;

   // ----------------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------------
   logic                       core_clk_i = 1'b0;
   logic                       reset_n_i  = 1'b0;
   logic                       ce_i       = 1'b1;
   ctr_fault_pkg::fault_cond_t c1_cond    = '0;
   ctr_fault_pkg::fault_cond_t c2_cond    = '0;
   logic                       c1_clr     = 1'b0;
   logic                       c2_clr     = 1'b0;
   logic                       c1_pre     = 1'b0;
   logic                       c2_pre     = 1'b0;
   logic                       c1_rst     = 1'b0;
   logic                       c2_rst     = 1'b0;
   logic                       c1_sv      = 1'b0;
   logic                       c2_sv      = 1'b0;
   logic [32:0]                c1_raw     = 33'h000000000;
   logic [32:0]                c2_raw     = 33'h000000000;
   logic                       f1, w1, lh1, ph1, f2, w2, lh2, ph2, io_err;
   logic [15:0]                fc1, wc1, fc2, wc2;
   logic [31:0]                sv1, sv2;
   int                         failures    = 0;
   int                         checks_done = 0;
   int                         cycles      = 0;

   always #10 core_clk_i = ~core_clk_i;

   ctr_fault_status dut (
      .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
      .ch1_cond_i(c1_cond), .ch1_fault_clear_cmd_i(c1_clr), .ch1_preset_i(c1_pre),
      .ch1_pulse_restart_i(c1_rst), .ch1_samp_valid_i(c1_sv), .ch1_samp_raw_i(c1_raw),
      .ch2_cond_i(c2_cond), .ch2_fault_clear_cmd_i(c2_clr), .ch2_preset_i(c2_pre),
      .ch2_pulse_restart_i(c2_rst), .ch2_samp_valid_i(c2_sv), .ch2_samp_raw_i(c2_raw),
      .ch1_fault_flag_o(f1), .ch1_caution_flag_o(w1), .ch1_fault_code_word_o(fc1),
      .ch1_caution_code_word_o(wc1), .ch1_lin_halt_o(lh1), .ch1_pulse_halt_o(ph1),
      .ch1_samp_value_o(sv1),
      .ch2_fault_flag_o(f2), .ch2_caution_flag_o(w2), .ch2_fault_code_word_o(fc2),
      .ch2_caution_code_word_o(wc2), .ch2_lin_halt_o(lh2), .ch2_pulse_halt_o(ph2),
      .ch2_samp_value_o(sv2), .io_err_o(io_err)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // one clock edge: inputs set at a falling edge are taken at the rising edge, read at the next fall
   task automatic cyc;
      @(negedge core_clk_i);
   endtask : cyc

   task automatic st1(input logic f, input logic w, input logic [15:0] fc, input logic [15:0] wc);
      chk("ch1 fault flag", 32'(f1), 32'(f));
      chk("ch1 caution flag", 32'(w1), 32'(w));
      chk("ch1 fault code", 32'(fc1), 32'(fc));
      chk("ch1 caution code", 32'(wc1), 32'(wc));
   endtask : st1

   task automatic st2(input logic f, input logic w, input logic [15:0] fc, input logic [15:0] wc);
      chk("ch2 fault flag", 32'(f2), 32'(f));
      chk("ch2 caution flag", 32'(w2), 32'(w));
      chk("ch2 fault code", 32'(fc2), 32'(fc));
      chk("ch2 caution code", 32'(wc2), 32'(wc));
   endtask : st2

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish

   // whole run is well under 100 cycles; the ceiling leaves ample margin
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 500) begin
         failures++;
         tally_and_finish();
      end
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(negedge core_clk_i);
      reset_n_i = 1'b1;
      st1(1'b0, 1'b0, 16'h0000, 16'h0000);
      st2(1'b0, 1'b0, 16'h0000, 16'h0000);
      $display("test reset done");

      // linear overflow on ch1, then a later pulse fault must not replace the code
      c1_cond.lin_ovf = 1'b1;
      cyc();
      st1(1'b1, 1'b0, 16'h0c1c, 16'h0000);
      chk("io error", 32'(io_err), 32'h1);
      chk("ch1 lin halt", 32'(lh1), 32'h1);
      st2(1'b0, 1'b0, 16'h0000, 16'h0000);
      chk("ch2 lin halt", 32'(lh2), 32'h0);
      c1_cond = 2'b01;
      cyc();
      chk("ch1 fault code kept", 32'(fc1), 32'h00000c1c);
      chk("ch1 pulse halt", 32'(ph1), 32'h1);
      c1_cond = 2'b00;
      c1_clr  = 1'b1;
      cyc();
      c1_clr  = 1'b0;
      st1(1'b0, 1'b0, 16'h0000, 16'h0000);
      chk("io error off", 32'(io_err), 32'h0);
      c1_pre  = 1'b1;
      cyc();
      c1_pre  = 1'b0;
      c1_rst  = 1'b1;
      chk("ch1 lin halt released", 32'(lh1), 32'h0);
      cyc();
      c1_rst  = 1'b0;
      chk("ch1 pulse halt released", 32'(ph1), 32'h0);
      $display("test ch1 fault done");

      // clearing while the cause persists stores the code again
      c1_cond = 2'b01;
      cyc();
      chk("ch1 pulse code", 32'(fc1), 32'h00000c80);
      c1_clr  = 1'b1;
      cyc();
      st1(1'b1, 1'b0, 16'h0c80, 16'h0000);
      c1_cond = 2'b10;
      cyc();
      st1(1'b1, 1'b0, 16'h0c1c, 16'h0000);
      chk("ch1 lin halt on redetect", 32'(lh1), 32'h1);
      c1_cond = 2'b00;
      cyc();
      c1_clr  = 1'b0;
      c1_rst  = 1'b1;
      c1_pre  = 1'b1;
      st1(1'b0, 1'b0, 16'h0000, 16'h0000);
      cyc();
      c1_rst  = 1'b0;
      c1_pre  = 1'b0;
      chk("ch1 halts released", 32'({lh1, ph1}), 32'h0);
      $display("test persistent fault done");

      // ch2 faults leave ch1 alone; a gated clock enable takes nothing
      c2_cond = 2'b10;
      cyc();
      st2(1'b1, 1'b0, 16'h1004, 16'h0000);
      st1(1'b0, 1'b0, 16'h0000, 16'h0000);
      chk("io error ch2", 32'(io_err), 32'h1);
      c2_cond = 2'b01;
      c2_clr  = 1'b1;
      cyc();
      st2(1'b1, 1'b0, 16'h1068, 16'h0000);
      c2_cond = 2'b00;
      cyc();
      c2_clr  = 1'b0;
      c2_pre  = 1'b1;
      c2_rst  = 1'b1;
      st2(1'b0, 1'b0, 16'h0000, 16'h0000);
      cyc();
      c2_pre  = 1'b0;
      c2_rst  = 1'b0;
      chk("ch2 halts released", 32'({lh2, ph2}), 32'h0);
      ce_i    = 1'b0;
      c1_cond = 2'b10;
      cyc();
      st1(1'b0, 1'b0, 16'h0000, 16'h0000);
      ce_i    = 1'b1;
      c1_cond = 2'b00;
      $display("test ch2 fault done");

      // sampling overflow: saturate both ways, never halt, re-detect on a persistent clear
      c1_sv   = 1'b1;
      c1_raw  = 33'h080000000;
      cyc();
      st1(1'b0, 1'b1, 16'h0000, 16'h0bea);
      chk("ch1 samp high", sv1, 32'h7fffffff);
      chk("no halt on caution", 32'({io_err, lh1, ph1}), 32'h0);
      c1_raw  = 33'h17fffffff;
      cyc();
      chk("ch1 samp low", sv1, 32'h80000000);
      chk("ch1 caution code", 32'(wc1), 32'h00000bea);
      c1_raw  = 33'h000000005;
      cyc();
      chk("ch1 samp keeps counting", sv1, 32'h00000005);
      c1_raw  = 33'h080000000;
      c1_clr  = 1'b1;
      cyc();
      st1(1'b0, 1'b1, 16'h0000, 16'h0bea);
      c1_raw  = 33'h1fffffff0;
      cyc();
      c1_clr  = 1'b0;
      c1_sv   = 1'b0;
      st1(1'b0, 1'b0, 16'h0000, 16'h0000);
      chk("ch1 samp negative", sv1, 32'hfffffff0);
      c2_sv   = 1'b1;
      c2_raw  = 33'h100000000;
      cyc();
      c2_sv   = 1'b0;
      st2(1'b0, 1'b1, 16'h0000, 16'h0fd2);
      chk("ch2 samp low", sv2, 32'h80000000);
      st1(1'b0, 1'b0, 16'h0000, 16'h0000);
      c2_clr  = 1'b1;
      cyc();
      c2_clr  = 1'b0;
      st2(1'b0, 1'b0, 16'h0000, 16'h0000);
      $display("test caution done");

      // both channels faulted at once, then an asynchronous reset in mid-run wipes all status
      c1_cond = 2'b10;
      c2_cond = 2'b01;
      cyc();
      c1_cond = 2'b00;
      c2_cond = 2'b00;
      st1(1'b1, 1'b0, 16'h0c1c, 16'h0000);
      st2(1'b1, 1'b0, 16'h1068, 16'h0000);
      chk("io error both", 32'(io_err), 32'h1);
      cyc();
      chk("io error held", 32'(io_err), 32'h1);
      reset_n_i = 1'b0;
      cyc();
      st1(1'b0, 1'b0, 16'h0000, 16'h0000);
      st2(1'b0, 1'b0, 16'h0000, 16'h0000);
      chk("halts after reset", 32'({lh1, ph1, lh2, ph2}), 32'h0);
      chk("ch1 samp after reset", sv1, 32'h00000000);
      chk("ch2 samp after reset", sv2, 32'h00000000);
      reset_n_i = 1'b1;
      cyc();
      st1(1'b0, 1'b0, 16'h0000, 16'h0000);
      chk("io error after reset", 32'(io_err), 32'h0);
      $display("test mid-run reset done");
      tally_and_finish();
   end

endmodule : ctr_fault_status_tb
